// >>> common/dhr_pkg.sv
package dhr_pkg;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [4:0] OFS_ADDR_LO  = 5'h00;
   localparam logic [4:0] OFS_ADDR_HI  = 5'h04;
   localparam logic [4:0] OFS_LENGTH   = 5'h08;
   localparam logic [4:0] OFS_CONTROL  = 5'h0C;
   localparam logic [4:0] OFS_IRQ      = 5'h10;
   localparam logic [4:0] OFS_MASTER   = 5'h14;

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int CTL_BUSY_BIT  = 31;
   localparam int CTL_RO_BIT    = 13;
   localparam int CTL_NS_BIT    = 12;
   localparam int CTL_TC_HI     = 10;
   localparam int CTL_TC_LO     = 8;
   localparam int CTL_FMT_HI    = 6;
   localparam int CTL_FMT_LO    = 5;
   localparam int CTL_TYPE_HI   = 4;
   localparam int CTL_TYPE_LO   = 0;
   localparam int CTL_PAT_HI    = 22;
   localparam int CTL_PAT_LO    = 20;
   localparam int CTL_PAY_HI    = 18;
   localparam int CTL_PAY_LO    = 16;
   localparam int CTL_TD_BIT    = 15;
   localparam int CTL_EP_BIT    = 14;
   // Writable control bits: 22:20, 18:12, 10:8, 6:0
   localparam logic [31:0] CTL_WMASK = 32'h0077F77F;

   // Header format encodings
   localparam logic [1:0] FMT_RD_3DW = 2'h0;
   localparam logic [1:0] FMT_RD_4DW = 2'h1;
   localparam logic [1:0] FMT_WR_3DW = 2'h2;
   localparam logic [1:0] FMT_WR_4DW = 2'h3;
   localparam logic [4:0] TYPE_MEM   = 5'h00;

   // ************************************************************
   // Interrupt register fields
   // ************************************************************
   localparam int IRQ_TC_HI    = 14;
   localparam int IRQ_TC_LO    = 12;
   localparam int IRQ_VEC_HI   = 8;
   localparam int IRQ_VEC_LO   = 4;
   localparam int IRQ_REQ_BIT  = 0;
   localparam logic [31:0] IRQ_WMASK = 32'h000071F0;

   // ************************************************************
   // Master block address fields
   // ************************************************************
   localparam int MST_HI       = 14;
   localparam int MST_LO       = 3;
   // Master address bits from this one down to bit 0 come from the bus address
   localparam int MST_BUS_HI   = 2;
   localparam logic [31:0] MST_WMASK = 32'h00007FF8;

   localparam logic [31:0] RESET_WORD = 32'h00000000;

endpackage

// >>> core/dhr_field_reg.sv
`timescale 1ns/10ps
`default_nettype none

// ***************************************************************
// One 32-bit register with write mask and byte enables
// ***************************************************************
module dhr_field_reg
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        wr,
   input  wire logic [3:0]  be,
   input  wire logic [31:0] wdata,
   input  wire logic [31:0] wmask,
   output var  logic [31:0] value
);

   logic [31:0] value_q;
   logic [31:0] value_d;
   logic [31:0] lane;

   // Byte lanes widened into a bit mask
   always_comb
   begin
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   end

   // Reserved bits never take a write, so they stay zero
   always_comb
   begin
      value_d = value_q;
      if (wr)
      begin
         value_d = (value_q & ~(lane & wmask)) | (wdata & lane & wmask);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         value_q <= dhr_pkg::RESET_WORD;
      end
      else if (ce)
      begin
         value_q <= value_d;
      end
   end

   assign value = value_q;

endmodule

`default_nettype wire

// >>> core/dhr_regs.sv
`timescale 1ns/10ps
`default_nettype none

module dhr_regs
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   input  wire logic        CE,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [4:0]  REG_ADDR,
   input  wire logic [3:0]  REG_BE,
   input  wire logic [31:0] REG_WDATA,
   output var  logic [31:0] REG_RDATA,
   input  wire logic        MSI_ENABLE,
   input  wire logic        DMA_DONE,
   output var  logic [63:0] DMA_BUS_ADDR,
   output var  logic [31:0] DMA_LENGTH,
   output var  logic [14:0] DMA_MASTER_ADDR,
   output var  logic        DMA_START,
   output var  logic        DMA_BUSY,
   output var  logic        HDR_RO,
   output var  logic        HDR_NS,
   output var  logic [2:0]  HDR_TC,
   output var  logic [1:0]  HDR_FMT,
   output var  logic [4:0]  HDR_TYPE,
   output var  logic [2:0]  HDR_PAYLOAD,
   output var  logic        HDR_TD,
   output var  logic        HDR_EP,
   output var  logic [2:0]  HDR_PATTERN,
   output var  logic        MSI_REQ,
   output var  logic        LEGACY_REQ,
   output var  logic [4:0]  MSI_VECTOR,
   output var  logic [2:0]  MSI_TC
);

   // ************************************************************
   // Address decode
   // ************************************************************
   function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
      hit = (a == o);
   endfunction

   logic [31:0] addr_lo, addr_hi, length, control, irq, master;
   logic        wr_lo, wr_hi, wr_len, wr_ctl, wr_irq, wr_mst;

   // Writes land only while the clock enable is high
   always_comb
   begin
      wr_lo  = CE & REG_WR & hit(REG_ADDR, dhr_pkg::OFS_ADDR_LO);
      wr_hi  = CE & REG_WR & hit(REG_ADDR, dhr_pkg::OFS_ADDR_HI);
      wr_len = CE & REG_WR & hit(REG_ADDR, dhr_pkg::OFS_LENGTH);
      wr_ctl = CE & REG_WR & hit(REG_ADDR, dhr_pkg::OFS_CONTROL);
      wr_irq = CE & REG_WR & hit(REG_ADDR, dhr_pkg::OFS_IRQ);
      wr_mst = CE & REG_WR & hit(REG_ADDR, dhr_pkg::OFS_MASTER);
   end

   // ************************************************************
   // Register storage
   // ************************************************************
   dhr_field_reg u_lo  (.clk(CLK_SYS), .rst(RESET), .ce(CE), .wr(wr_lo),
      .be(REG_BE), .wdata(REG_WDATA), .wmask(32'hFFFFFFFF), .value(addr_lo));
   dhr_field_reg u_hi  (.clk(CLK_SYS), .rst(RESET), .ce(CE), .wr(wr_hi),
      .be(REG_BE), .wdata(REG_WDATA), .wmask(32'hFFFFFFFF), .value(addr_hi));
   dhr_field_reg u_len (.clk(CLK_SYS), .rst(RESET), .ce(CE), .wr(wr_len),
      .be(REG_BE), .wdata(REG_WDATA), .wmask(32'hFFFFFFFF), .value(length));
   dhr_field_reg u_ctl (.clk(CLK_SYS), .rst(RESET), .ce(CE), .wr(wr_ctl),
      .be(REG_BE), .wdata(REG_WDATA), .wmask(dhr_pkg::CTL_WMASK),
      .value(control));
   dhr_field_reg u_irq (.clk(CLK_SYS), .rst(RESET), .ce(CE), .wr(wr_irq),
      .be(REG_BE), .wdata(REG_WDATA), .wmask(dhr_pkg::IRQ_WMASK),
      .value(irq));
   dhr_field_reg u_mst (.clk(CLK_SYS), .rst(RESET), .ce(CE), .wr(wr_mst),
      .be(REG_BE), .wdata(REG_WDATA), .wmask(dhr_pkg::MST_WMASK),
      .value(master));

   // ************************************************************
   // Busy flag, strobes and read data
   // ************************************************************
   logic        busy_q, busy_d, start_q, start_d;
   logic        msi_q, msi_d, leg_q, leg_d;
   logic [31:0] rdata_q, rdata_d;
   logic        irq_hit;

   // A new start wins over a done seen in the same cycle
   always_comb
   begin
      irq_hit = wr_irq & REG_BE[0] & REG_WDATA[dhr_pkg::IRQ_REQ_BIT];
      start_d = wr_ctl;
      busy_d  = busy_q;
      if (DMA_DONE)
      begin
         busy_d = 1'b0;
      end
      if (wr_ctl)
      begin
         busy_d = 1'b1;
      end
      msi_d = irq_hit & MSI_ENABLE;
      leg_d = irq_hit & ~MSI_ENABLE;
      rdata_d = rdata_q;
      if (CE & REG_RD)
      begin
         case (REG_ADDR)
            dhr_pkg::OFS_ADDR_LO: rdata_d = addr_lo;
            dhr_pkg::OFS_ADDR_HI: rdata_d = addr_hi;
            dhr_pkg::OFS_LENGTH:  rdata_d = length;
            dhr_pkg::OFS_CONTROL: rdata_d = control |
               ({31'h00000000, busy_q} << dhr_pkg::CTL_BUSY_BIT);
            dhr_pkg::OFS_IRQ:     rdata_d = irq;
            dhr_pkg::OFS_MASTER:  rdata_d = master;
            default:              rdata_d = 32'h00000000;
         endcase
      end
   end

   // One write makes one pulse; CE low freezes it with the rest
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         busy_q  <= 1'b0;
         start_q <= 1'b0;
         msi_q   <= 1'b0;
         leg_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else if (CE)
      begin
         busy_q  <= busy_d;
         start_q <= start_d;
         msi_q   <= msi_d;
         leg_q   <= leg_d;
         rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   logic [63:0] bus_addr_d;
   logic [31:0] length_d;
   logic [14:0] master_d;
   logic        ro_d;
   logic        ns_d;
   logic [2:0]  tc_d;
   logic [1:0]  fmt_d;
   logic [4:0]  type_d;
   logic [2:0]  payload_d;
   logic        td_d;
   logic        ep_d;
   logic [2:0]  pattern_d;
   logic [4:0]  vector_d;
   logic [2:0]  msi_tc_d;

   // Fields picked from the stored words; a flop stage keeps ports clean
   always_comb
   begin
      bus_addr_d = {addr_hi, addr_lo};
      length_d   = length;
      // Low master bits follow the bus address, not the master register
      master_d   = {master[dhr_pkg::MST_HI:dhr_pkg::MST_LO],
                    addr_lo[dhr_pkg::MST_BUS_HI:0]};
      ro_d       = control[dhr_pkg::CTL_RO_BIT];
      ns_d       = control[dhr_pkg::CTL_NS_BIT];
      tc_d       = control[dhr_pkg::CTL_TC_HI:dhr_pkg::CTL_TC_LO];
      fmt_d      = control[dhr_pkg::CTL_FMT_HI:dhr_pkg::CTL_FMT_LO];
      type_d     = control[dhr_pkg::CTL_TYPE_HI:
                           dhr_pkg::CTL_TYPE_LO];
      payload_d  = control[dhr_pkg::CTL_PAY_HI:dhr_pkg::CTL_PAY_LO];
      td_d       = control[dhr_pkg::CTL_TD_BIT];
      ep_d       = control[dhr_pkg::CTL_EP_BIT];
      pattern_d  = control[dhr_pkg::CTL_PAT_HI:dhr_pkg::CTL_PAT_LO];
      vector_d   = irq[dhr_pkg::IRQ_VEC_HI:dhr_pkg::IRQ_VEC_LO];
      msi_tc_d   = irq[dhr_pkg::IRQ_TC_HI:dhr_pkg::IRQ_TC_LO];
   end

   // Costs one cycle of latency, buys glitch-free header outputs
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         DMA_BUS_ADDR    <= 64'h0000000000000000;
         DMA_LENGTH      <= 32'h00000000;
         DMA_MASTER_ADDR <= 15'h0000;
         HDR_RO          <= 1'b0;
         HDR_NS          <= 1'b0;
         HDR_TC          <= 3'h0;
         HDR_FMT         <= 2'h0;
         HDR_TYPE        <= 5'h00;
         HDR_PAYLOAD     <= 3'h0;
         HDR_TD          <= 1'b0;
         HDR_EP          <= 1'b0;
         HDR_PATTERN     <= 3'h0;
         MSI_VECTOR      <= 5'h00;
         MSI_TC          <= 3'h0;
      end
      else if (CE)
      begin
         DMA_BUS_ADDR    <= bus_addr_d;
         DMA_LENGTH      <= length_d;
         DMA_MASTER_ADDR <= master_d;
         HDR_RO          <= ro_d;
         HDR_NS          <= ns_d;
         HDR_TC          <= tc_d;
         HDR_FMT         <= fmt_d;
         HDR_TYPE        <= type_d;
         HDR_PAYLOAD     <= payload_d;
         HDR_TD          <= td_d;
         HDR_EP          <= ep_d;
         HDR_PATTERN     <= pattern_d;
         MSI_VECTOR      <= vector_d;
         MSI_TC          <= msi_tc_d;
      end
   end

   assign REG_RDATA  = rdata_q;
   assign DMA_START  = start_q;
   assign DMA_BUSY   = busy_q;
   assign MSI_REQ    = msi_q;
   assign LEGACY_REQ = leg_q;

endmodule

`default_nettype wire

// >>> tb/dhr_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************
// Port checker
// ***************************
module dhr_regs_monitor
(
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   input wire logic        CE,
   input wire logic        REG_WR,
   input wire logic [4:0]  REG_ADDR,
   input wire logic [3:0]  REG_BE,
   input wire logic [31:0] REG_WDATA,
   input wire logic        MSI_ENABLE,
   input wire logic        DMA_DONE,
   input wire logic [14:0] DMA_MASTER_ADDR,
   input wire logic        DMA_START,
   input wire logic        DMA_BUSY,
   input wire logic        HDR_RO,
   input wire logic        HDR_NS,
   input wire logic [2:0]  HDR_TC,
   input wire logic [1:0]  HDR_FMT,
   input wire logic [4:0]  HDR_TYPE,
   input wire logic        MSI_REQ,
   input wire logic        LEGACY_REQ,
   input wire logic [4:0]  MSI_VECTOR,
   input wire logic [2:0]  MSI_TC
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   logic [31:0] wd1_q;
   logic [31:0] wd2_q;
   wire         cw = CE && REG_WR && REG_ADDR == dhr_pkg::OFS_CONTROL;
   wire         iw = CE && REG_WR && REG_ADDR == dhr_pkg::OFS_IRQ;
   wire         mw = CE && REG_WR && REG_ADDR == dhr_pkg::OFS_MASTER;
   wire         rq = iw && REG_BE[0] && REG_WDATA[0];
   // Write data two edges back, when field outputs settle
   always_ff @(posedge CLK_SYS)
   begin
      wd1_q <= REG_WDATA;
      wd2_q <= wd1_q;
   end
   a_ctrl_starts: assert property (cw |=> DMA_START && DMA_BUSY)
      else $error("control write did not start");
   a_busy_clears: assert property (
      CE && DMA_DONE && !cw |=> !DMA_BUSY)
      else $error("busy stayed after done");
   a_hdr_attr: assert property (cw && REG_BE[1] |=> ##1
      {HDR_RO, HDR_NS, HDR_TC} == {wd2_q[13:12], wd2_q[10:8]})
      else $error("header attributes wrong");
   a_hdr_fmt: assert property (cw && REG_BE[0] |=> ##1
      {HDR_FMT, HDR_TYPE} == wd2_q[6:0])
      else $error("header format or type wrong");
   a_msi_sent: assert property (
      rq && MSI_ENABLE |=> MSI_REQ && !LEGACY_REQ)
      else $error("no interrupt message");
   a_legacy_sent: assert property (rq && !MSI_ENABLE |=> LEGACY_REQ)
      else $error("no legacy message");
   a_req_cause: assert property (MSI_REQ || LEGACY_REQ |-> $past(rq))
      else $error("message without request");
   a_msi_fields: assert property (iw && REG_BE[1:0] == 2'h3 |=> ##1
      {MSI_TC, MSI_VECTOR} == {wd2_q[14:12], wd2_q[8:4]})
      else $error("message fields wrong");
   a_master_hi: assert property (mw && REG_BE[1:0] == 2'h3 |=> ##1
      DMA_MASTER_ADDR[14:3] == wd2_q[14:3])
      else $error("master address wrong");
   c_msi: cover property (MSI_REQ);
   c_legacy: cover property (LEGACY_REQ);
   c_done: cover property (DMA_BUSY ##1 !DMA_BUSY);
endmodule
bind dhr_regs dhr_regs_monitor u_mon (.CLK_SYS, .RESET, .CE, .REG_WR,
   .REG_ADDR, .REG_BE, .REG_WDATA, .MSI_ENABLE, .DMA_DONE, .DMA_MASTER_ADDR,
   .DMA_START, .DMA_BUSY, .HDR_RO, .HDR_NS, .HDR_TC, .HDR_FMT, .HDR_TYPE,
   .MSI_REQ, .LEGACY_REQ, .MSI_VECTOR, .MSI_TC);
`default_nettype wire

// >>> tb/dhr_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************
// Engine stand-in
// ***************************
module dhr_engine_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [7:0] lat,
   output var  logic       done
);
   logic [7:0] cnt_q;
   logic       run_q;
   // Finish lat+1 cycles after start; a new start restarts the count
   always_ff @(posedge clk)
   begin
      done <= 1'b0;
      if (rst)
         run_q <= 1'b0;
      else if (start)
      begin
         run_q <= 1'b1;
         cnt_q <= lat;
      end
      else if (run_q)
      begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h00)
         begin
            run_q <= 1'b0;
            done  <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, msi_en = 1'b0;
   logic        ce = 1'b1;
   logic [4:0]  addr = 5'h00;
   logic [3:0]  be = 4'h0;
   logic [31:0] wd = 32'h0, rdata, d, len;
   logic [7:0]  lat = 8'h14;
   logic [63:0] bus_addr;
   logic [14:0] mst;
   logic [4:0]  vec, typ;
   logic [2:0]  tc, mtc, pay, pat;
   logic [1:0]  fmt;
   logic        done, start, ro, ns, msi, leg, busy, td, ep;
   int          miscompares = 0, n_tests = 0, cyc = 0;
   // Clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         miscompares++;
         conclude();
      end
   end
   dhr_regs dut (.CLK_SYS(clk), .RESET(rst), .CE(ce), .REG_WR(wr),
      .REG_RD(rd), .REG_ADDR(addr), .REG_BE(be), .REG_WDATA(wd),
      .REG_RDATA(rdata), .MSI_ENABLE(msi_en), .DMA_DONE(done),
      .DMA_BUS_ADDR(bus_addr), .DMA_LENGTH(len), .DMA_MASTER_ADDR(mst),
      .DMA_START(start), .DMA_BUSY(busy), .HDR_RO(ro), .HDR_NS(ns),
      .HDR_TC(tc), .HDR_FMT(fmt), .HDR_TYPE(typ), .HDR_PAYLOAD(pay),
      .HDR_TD(td), .HDR_EP(ep), .HDR_PATTERN(pat), .MSI_REQ(msi),
      .LEGACY_REQ(leg), .MSI_VECTOR(vec), .MSI_TC(mtc));
   dhr_engine_model eng (.clk(clk), .rst(rst), .start(start), .lat(lat),
      .done(done));
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      n_tests++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] %0t saw %h want %h", $time, s, e);
      end
   endtask
   // Inputs move on the falling edge only
   task automatic wr_reg(input logic [4:0] a, input logic [3:0] b,
                         input logic [31:0] v);
      @(negedge clk);
      {wr, addr, be, wd} = {1'b1, a, b, v};
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a, input logic [31:0] e);
      @(negedge clk);
      {rd, addr} = {1'b1, a};
      @(negedge clk);
      rd = 1'b0;
      chk(rdata, e);
   endtask
   task automatic pulses(input int em, input int el);
      int m, l;
      {m, l} = 0;
      repeat (4)
      begin
         m += int'(msi === 1'b1);
         l += int'(leg === 1'b1);
         @(negedge clk);
      end
      chk(m, em);
      chk(l, el);
   endtask
   task automatic conclude;
      if (miscompares == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      rd_reg(dhr_pkg::OFS_IRQ, 32'h0);
      rd_reg(dhr_pkg::OFS_MASTER, 32'h0);
      wr_reg(dhr_pkg::OFS_ADDR_LO, 4'hF, 32'h89ABCDE5);
      // A write while the clock enable is low must leave no trace
      ce = 1'b0;
      wr_reg(dhr_pkg::OFS_ADDR_LO, 4'hF, 32'h00000000);
      ce = 1'b1;
      wr_reg(dhr_pkg::OFS_ADDR_HI, 4'hF, 32'h01234567);
      wr_reg(dhr_pkg::OFS_LENGTH, 4'h3, 32'hCAFE1234);
      wr_reg(dhr_pkg::OFS_MASTER, 4'hF, 32'hFFFFFFFF);
      rd_reg(dhr_pkg::OFS_MASTER, 32'h00007FF8);
      rd_reg(dhr_pkg::OFS_LENGTH, 32'h00001234);
      chk(bus_addr, 64'h0123456789ABCDE5);
      chk(len, 32'h00001234);
      chk(mst, 15'h7FFD);
      // Reserved bits 23, 19, 11 and 7 are set to prove they never stick
      for (int f = 0; f < 4; f++)
      begin
         d = 32'hFFDB8880;
         {d[15:12], d[10:8], d[6:5]} = {f[1:0], f[0], f[1], 3'(5 - f), f[1:0]};
         wr_reg(dhr_pkg::OFS_CONTROL, 4'hF, d);
         @(negedge clk);
         chk({ro, ns, tc}, {d[13:12], d[10:8]});
         chk({fmt, typ}, {d[6:5], 5'h00});
         chk({pat, pay, td, ep}, {d[22:20], d[18:14]});
         d = d & 32'h0077F77F;
         rd_reg(dhr_pkg::OFS_CONTROL, d | 32'h80000000);
         chk(busy, 1'b1);
         repeat (25) @(negedge clk);
         rd_reg(dhr_pkg::OFS_CONTROL, d);
         chk(busy, 1'b0);
      end
      lat = 8'h00;
      wr_reg(dhr_pkg::OFS_CONTROL, 4'h0, 32'h0);
      chk(start, 1'b1);
      msi_en = 1'b1;
      wr_reg(dhr_pkg::OFS_IRQ, 4'hF, 32'h00005A31);
      pulses(1, 0);
      chk({mtc, vec}, {3'h5, 5'h03});
      rd_reg(dhr_pkg::OFS_IRQ, 32'h00005030);
      msi_en = 1'b0;
      wr_reg(dhr_pkg::OFS_IRQ, 4'h1, 32'h00000001);
      pulses(0, 1);
      wr_reg(dhr_pkg::OFS_IRQ, 4'hE, 32'h00000001);
      pulses(0, 0);
      wr_reg(5'h18, 4'hF, 32'hFFFFFFFF);
      rd_reg(5'h18, 32'h0);
      // Reset in mid-run, with an operation under way, clears it all
      lat = 8'h14;
      wr_reg(dhr_pkg::OFS_CONTROL, 4'hF, 32'h00000001);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd_reg(dhr_pkg::OFS_CONTROL, 32'h0);
      chk(busy, 1'b0);
      chk(bus_addr, 64'h0);
      conclude();
   end
endmodule
`default_nettype wire
